// *** dssp_top.sv ***
// Top: dual synthesizer serial program port, control registers and APB view
// Summary of operation
// - Serial data shifts into a 22-bit register on each serial clock rise.
// - First bit shifted in is the word's most significant bit.
// - Last two bits of each word select the destination register.
// - Load strobe rising edge copies the word into one of four registers.
// - Status pin shows GP level, lock, divider output or fast-acq switch.
// - Main prescaler runs 16/17 or 32/33 as programmed.
// - Aux prescaler runs 8/9 or 16/17 as programmed.
// - Power-down may be programmed synchronous or asynchronous.
// - Each charge pump can be set high impedance.
// - Per-loop bit picks low or high charge-pump current.
// - Fast acquisition exists for the main loop only.
// - Each loop has a 15-bit reference and 18-bit feedback divider.
// - Reference divide values run from 2 to 32767.
// - Separate power-down bits; 1 powers that loop down.
`timescale 1ns/1ps
`default_nettype none
module dssp_top
   import dssp_pkg::*;
(
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic        SERIAL_CLOCK,
   input  wire logic        SERIAL_DATA,
   input  wire logic        LOAD_STROBE,
   input  wire logic        MAIN_LOCK,
   input  wire logic        AUX_LOCK,
   input  wire logic        MAIN_NDIV_OUT,
   input  wire logic        MAIN_RDIV_OUT,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output var  logic [31:0] PRDATA,
   output var  logic        PREADY,
   output var  logic        PSLVERR,
   output var  logic        MULTIPLEXED_STATUS_PIN,
   output var  logic        MULTIPLEXED_STATUS_PIN_OE_N,
   output var  dssp_cfg_s   CFG,
   output var  logic        MAIN_ACTIVE,
   output var  logic        AUX_ACTIVE,
   output var  logic        RDIV_FAULT
);
   logic [SHIFT_W-1:0] held_word;
   logic               word_toggle;
   logic               tog_sync;
   logic               tog_last;
   logic [SHIFT_W-1:0] word_a;
   logic [SHIFT_W-1:0] word_b;
   logic               load_pulse;
   logic               load_pending;
   logic [1:0]         pend_cnt;
   dssp_regs_s         regs;
   logic [2:0]         lock_sync;
   logic [2:0]         lock_in;
   logic               main_rdiv_sync;
   logic               gp_level;
   logic               loads_enabled;
   logic [15:0]        load_count;
   logic               next_main_active;
   logic               next_aux_active;
   logic [PAYLOAD_W-1:0] wp;

   dssp_shift u_shift (
      .serial_clock (SERIAL_CLOCK),
      .serial_data  (SERIAL_DATA),
      .load_strobe  (LOAD_STROBE),
      .held_word    (held_word),
      .word_toggle  (word_toggle)
   );

   // Event crossing: toggle synchronised, then word sampled once it is stable
   dssp_sync #(.W(1)) u_tog_sync (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .d     (word_toggle),
      .q     (tog_sync)
   );

   dssp_sync #(.W(3)) u_pin_sync (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .d     ({MAIN_LOCK, AUX_LOCK, MAIN_NDIV_OUT}),
      .q     (lock_in)
   );

   dssp_sync #(.W(1)) u_rdiv_sync (
      .clk   (REF_CLK),
      .rst_n (RST_N),
      .d     (MAIN_RDIV_OUT),
      .q     (main_rdiv_sync)
   );

   assign lock_sync = lock_in;

   // Held word is stable for many cycles after the toggle; sample twice to be safe
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         tog_last     <= 1'b0;
         load_pending <= 1'b0;
         pend_cnt     <= 2'h0;
         load_pulse   <= 1'b0;
         word_a       <= '0;
         word_b       <= '0;
      end else begin
         tog_last   <= tog_sync;
         load_pulse <= 1'b0;
         word_a     <= held_word;
         word_b     <= word_a;
         if (tog_sync != tog_last) begin
            load_pending <= 1'b1;
            pend_cnt     <= 2'h0;
         end else if (load_pending) begin
            pend_cnt <= pend_cnt + 2'h1;
            if (pend_cnt == 2'h2) begin
               load_pending <= 1'b0;
               load_pulse   <= 1'b1;
            end
         end
      end
   end

   assign wp = word_b[SHIFT_W-1:CTRL_W];

   // Only a completed latch or an APB write updates a register; shifting alone never does
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         regs <= '0;
      end else if (load_pulse && loads_enabled) begin
         if (word_b[CTRL_W-1:0] == SEL_MAIN_R) begin
            regs.main_r <= wp;
         end else if (word_b[CTRL_W-1:0] == SEL_MAIN_N) begin
            regs.main_n <= wp;
         end else if (word_b[CTRL_W-1:0] == SEL_AUX_R) begin
            regs.aux_r <= wp;
         end else begin
            regs.aux_n <= wp;
         end
      end else if (PSEL && PENABLE && PWRITE) begin
         if (PADDR == A_MAIN_R) begin
            regs.main_r <= PWDATA[PAYLOAD_W-1:0];
         end else if (PADDR == A_MAIN_N) begin
            regs.main_n <= PWDATA[PAYLOAD_W-1:0];
         end else if (PADDR == A_AUX_R) begin
            regs.aux_r <= PWDATA[PAYLOAD_W-1:0];
         end else if (PADDR == A_AUX_N) begin
            regs.aux_n <= PWDATA[PAYLOAD_W-1:0];
         end
      end
   end

   // Software gate on serial loads, plus GP level for the status pin
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         loads_enabled <= 1'b1;
         gp_level      <= 1'b0;
      end else if (PSEL && PENABLE && PWRITE && PADDR == A_CONTROL) begin
         loads_enabled <= PWDATA[0];
         gp_level      <= PWDATA[1];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         load_count <= 16'h0000;
      end else if (load_pulse && loads_enabled) begin
         load_count <= load_count + 16'h0001;
      end
   end

   // Decoded configuration feeding the analog loops
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         CFG <= '0;
      end else begin
         CFG.main_rdiv           <= regs.main_r[F_RDIV_LSB +: RDIV_W];
         CFG.aux_rdiv            <= regs.aux_r[F_RDIV_LSB +: RDIV_W];
         CFG.main_ndiv           <= regs.main_n[F_NDIV_LSB +: NDIV_W];
         CFG.aux_ndiv            <= regs.aux_n[F_NDIV_LSB +: NDIV_W];
         CFG.main_prescale_32    <= regs.main_n[F_PRESC];
         CFG.aux_prescale_16     <= regs.aux_n[F_PRESC];
         CFG.main_cp_hiz         <= regs.main_r[F_CPHIZ];
         CFG.aux_cp_hiz          <= regs.aux_r[F_CPHIZ];
         CFG.main_cp_high        <= regs.main_r[F_CPHI];
         CFG.aux_cp_high         <= regs.aux_r[F_CPHI];
         CFG.main_power_down_bit <= regs.main_r[F_PWDN];
         CFG.aux_power_down_bit  <= regs.aux_r[F_PWDN];
         CFG.main_pwdn_async     <= regs.main_r[F_PWDN_ASYNC];
         CFG.aux_pwdn_async      <= regs.aux_r[F_PWDN_ASYNC];
         CFG.main_fast_acq       <= regs.main_r[F_FASTACQ];
         CFG.status_mode         <= regs.main_n[F_MUX_LSB +: MUX_W];
      end
   end

   // Async power-down drops at once; sync, for either loop, waits for the main feedback divider output (MAIN_NDIV_OUT)
   always_comb begin
      next_main_active = MAIN_ACTIVE;
      next_aux_active  = AUX_ACTIVE;
      if (!CFG.main_power_down_bit) begin
         next_main_active = 1'b1;
      end else if (CFG.main_pwdn_async || lock_sync[0]) begin
         next_main_active = 1'b0;
      end
      if (!CFG.aux_power_down_bit) begin
         next_aux_active = 1'b1;
      end else if (CFG.aux_pwdn_async || lock_sync[0]) begin
         next_aux_active = 1'b0;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         MAIN_ACTIVE <= 1'b0;
         AUX_ACTIVE  <= 1'b0;
         RDIV_FAULT  <= 1'b0;
      end else begin
         MAIN_ACTIVE <= next_main_active;
         AUX_ACTIVE  <= next_aux_active;
         // A divide value below 2 is outside the supported range
         RDIV_FAULT  <= (CFG.main_rdiv < RDIV_MIN) || (CFG.aux_rdiv < RDIV_MIN) ||
                        (CFG.main_rdiv > RDIV_MAX);
      end
   end

   // Status pin; OE_N low drives, lock modes are open drain (drive low only)
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         MULTIPLEXED_STATUS_PIN      <= 1'b0;
         MULTIPLEXED_STATUS_PIN_OE_N <= 1'b1;
      end else begin
         MULTIPLEXED_STATUS_PIN <= 1'b0;
         case (CFG.status_mode)
            MUX_GP_LOW: begin
               MULTIPLEXED_STATUS_PIN_OE_N <= 1'b0;
            end
            MUX_GP_HIGH: begin
               MULTIPLEXED_STATUS_PIN      <= gp_level;
               MULTIPLEXED_STATUS_PIN_OE_N <= 1'b0;
            end
            MUX_LOCK_MAIN: begin
               MULTIPLEXED_STATUS_PIN_OE_N <= lock_sync[2];
            end
            MUX_LOCK_AUX: begin
               MULTIPLEXED_STATUS_PIN_OE_N <= lock_sync[1];
            end
            MUX_NDIV: begin
               MULTIPLEXED_STATUS_PIN      <= lock_sync[0];
               MULTIPLEXED_STATUS_PIN_OE_N <= 1'b0;
            end
            MUX_RDIV: begin
               MULTIPLEXED_STATUS_PIN      <= main_rdiv_sync;
               MULTIPLEXED_STATUS_PIN_OE_N <= 1'b0;
            end
            MUX_FASTACQ: begin
               // Switch closes (pin pulled low) while fast acquisition is on
               MULTIPLEXED_STATUS_PIN_OE_N <= ~CFG.main_fast_acq;
            end
            default: begin
               MULTIPLEXED_STATUS_PIN_OE_N <= 1'b1;
            end
         endcase
      end
   end

   // APB slave: zero wait states on read and write, read data registered in the setup cycle
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         PRDATA  <= ZERO32;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL && !PENABLE;
         PSLVERR <= 1'b0;
         PRDATA  <= ZERO32;
         if (PSEL && !PENABLE) begin
            if (PADDR == A_MAIN_R) begin
               PRDATA <= {12'h000, regs.main_r};
            end else if (PADDR == A_MAIN_N) begin
               PRDATA <= {12'h000, regs.main_n};
            end else if (PADDR == A_AUX_R) begin
               PRDATA <= {12'h000, regs.aux_r};
            end else if (PADDR == A_AUX_N) begin
               PRDATA <= {12'h000, regs.aux_n};
            end else if (PADDR == A_STATUS) begin
               PRDATA <= {27'h000_0000, RDIV_FAULT, lock_sync[2], lock_sync[1],
                          MAIN_ACTIVE, AUX_ACTIVE};
            end else if (PADDR == A_CONTROL) begin
               PRDATA <= {30'h0000_0000, gp_level, loads_enabled};
            end else if (PADDR == A_COUNT) begin
               PRDATA <= {16'h0000, load_count};
            end else begin
               PSLVERR <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// *** dssp_pkg.sv ***
// Package: constants, types and register map of the dual synth serial program port
package dssp_pkg;

   localparam int SHIFT_W   = 22;
   localparam int CTRL_W    = 2;
   localparam int PAYLOAD_W = SHIFT_W - CTRL_W;
   localparam int RDIV_W    = 15;
   localparam int NDIV_W    = 18;

   // Control-bit codes choosing the destination register
   localparam logic [1:0] SEL_AUX_R  = 2'h0;
   localparam logic [1:0] SEL_AUX_N  = 2'h1;
   localparam logic [1:0] SEL_MAIN_R = 2'h2;
   localparam logic [1:0] SEL_MAIN_N = 2'h3;

   // Reference divider legal range
   localparam logic [14:0] RDIV_MIN = 15'h0002;
   localparam logic [14:0] RDIV_MAX = 15'h7fff;

   // Field positions inside the 20-bit payload
   localparam int F_RDIV_LSB   = 0;
   localparam int F_CPHIZ      = 15;
   localparam int F_CPHI       = 16;
   localparam int F_PWDN       = 17;
   localparam int F_PWDN_ASYNC = 18;
   localparam int F_FASTACQ    = 19;
   localparam int F_NDIV_LSB   = 0;
   localparam int F_PRESC      = 18;
   localparam int F_MUX_LSB    = 15;
   localparam int MUX_W        = 3;

   // Status pin modes
   localparam logic [2:0] MUX_GP_LOW   = 3'h0;
   localparam logic [2:0] MUX_GP_HIGH  = 3'h1;
   localparam logic [2:0] MUX_LOCK_MAIN = 3'h2;
   localparam logic [2:0] MUX_LOCK_AUX = 3'h3;
   localparam logic [2:0] MUX_NDIV     = 3'h4;
   localparam logic [2:0] MUX_RDIV     = 3'h5;
   localparam logic [2:0] MUX_FASTACQ  = 3'h6;
   localparam logic [2:0] MUX_HIZ      = 3'h7;

   // APB register byte offsets
   localparam logic [7:0] A_MAIN_R  = 8'h00;
   localparam logic [7:0] A_MAIN_N  = 8'h04;
   localparam logic [7:0] A_AUX_R   = 8'h08;
   localparam logic [7:0] A_AUX_N   = 8'h0c;
   localparam logic [7:0] A_STATUS  = 8'h10;
   localparam logic [7:0] A_CONTROL = 8'h14;
   localparam logic [7:0] A_COUNT   = 8'h18;

   localparam logic [31:0] ZERO32     = 32'h0000_0000;
   localparam logic [19:0] RESET_WORD = 20'h0000_0;

   typedef struct packed {
      logic [PAYLOAD_W-1:0] main_r;
      logic [PAYLOAD_W-1:0] main_n;
      logic [PAYLOAD_W-1:0] aux_r;
      logic [PAYLOAD_W-1:0] aux_n;
   } dssp_regs_s;

   typedef struct packed {
      logic                 main_prescale_32;
      logic                 aux_prescale_16;
      logic                 main_cp_hiz;
      logic                 aux_cp_hiz;
      logic                 main_cp_high;
      logic                 aux_cp_high;
      logic                 main_power_down_bit;
      logic                 aux_power_down_bit;
      logic                 main_pwdn_async;
      logic                 aux_pwdn_async;
      logic                 main_fast_acq;
      logic [MUX_W-1:0]     status_mode;
      logic [RDIV_W-1:0]    main_rdiv;
      logic [RDIV_W-1:0]    aux_rdiv;
      logic [NDIV_W-1:0]    main_ndiv;
      logic [NDIV_W-1:0]    aux_ndiv;
   } dssp_cfg_s;

endpackage

// *** dssp_sync.sv ***
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module dssp_sync
   import dssp_pkg::*;
#(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// *** dssp_shift.sv ***
// Serial-clock domain: 22-bit shifter and latch-strobe word capture
`timescale 1ns/1ps
`default_nettype none
module dssp_shift
   import dssp_pkg::*;
(
   input  wire logic               serial_clock,
   input  wire logic               serial_data,
   input  wire logic               load_strobe,
   output var  logic [SHIFT_W-1:0] held_word,
   output var  logic               word_toggle
);
   logic [SHIFT_W-1:0] shift_reg;

   // MSB enters first and walks up to the top
   always_ff @(posedge serial_clock) begin
      shift_reg <= {shift_reg[SHIFT_W-2:0], serial_data};
   end

   // No reset on this side: the port has none, the clock may stop.
   // Word is held stable and announced by a toggle so the system side reads it safely.
   always_ff @(posedge load_strobe) begin
      held_word <= shift_reg;
      // Branch form lets an unknown power-up level settle on the first strobe
      if (word_toggle) begin
         word_toggle <= 1'b0;
      end else begin
         word_toggle <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** dssp_top_monitor.sv ***
// Assertion checker for the serial program port top
`timescale 1ns/1ps
`default_nettype none
module dssp_monitor
   import dssp_pkg::*;
(
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire logic        LOAD_STROBE,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        MULTIPLEXED_STATUS_PIN,
   input wire logic        MULTIPLEXED_STATUS_PIN_OE_N,
   input wire dssp_cfg_s   CFG,
   input wire logic        MAIN_ACTIVE,
   input wire logic        AUX_ACTIVE,
   input wire logic        RDIV_FAULT
);
   logic       strobe_q;
   logic [4:0] ld_age;
   logic [1:0] wr_age;

   // Strobe sampled raw here; the design's sync delay fits inside the age window
   always_ff @(posedge REF_CLK) begin
      strobe_q <= LOAD_STROBE;
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) ld_age <= 5'h1f;
      else if (LOAD_STROBE && !strobe_q) ld_age <= 5'h00;
      else if (ld_age != 5'h1f) ld_age <= ld_age + 5'h01;
   end

   always_ff @(posedge REF_CLK) begin
      if (!RST_N || (PSEL && PENABLE && PWRITE && PREADY)) wr_age <= 2'h0;
      else if (wr_age != 2'h3) wr_age <= wr_age + 2'h1;
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   property p_ready; PSEL && !PENABLE |=> PREADY ##1 !PREADY; endproperty
   a_ready: assert property (p_ready) else $error("ready not single access cycle");
   property p_slverr; PSEL && !PENABLE && PADDR > A_COUNT |=> PSLVERR && PRDATA == ZERO32; endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
   property p_quiet; $changed(CFG) |-> ld_age < 5'h10 || wr_age < 2'h3; endproperty
   a_quiet: assert property (p_quiet) else $error("config changed without load or write");
   property p_main_on; (!CFG.main_power_down_bit) [*4] |-> MAIN_ACTIVE; endproperty
   a_main_on: assert property (p_main_on) else $error("main loop not active");
   property p_main_off; CFG.main_power_down_bit && CFG.main_pwdn_async |-> ##[0:2] !MAIN_ACTIVE; endproperty
   a_main_off: assert property (p_main_off) else $error("main async power-down late");
   property p_aux_off; CFG.aux_power_down_bit && CFG.aux_pwdn_async |-> ##[0:2] !AUX_ACTIVE; endproperty
   a_aux_off: assert property (p_aux_off) else $error("aux async power-down late");
   property p_hiz; (CFG.status_mode == MUX_HIZ) [*3] |-> MULTIPLEXED_STATUS_PIN_OE_N; endproperty
   a_hiz: assert property (p_hiz) else $error("status pin not released");
   property p_low;
      (CFG.status_mode == MUX_GP_LOW) [*3] |-> !MULTIPLEXED_STATUS_PIN_OE_N && !MULTIPLEXED_STATUS_PIN;
   endproperty
   a_low: assert property (p_low) else $error("status pin not driven low");
   property p_rdiv; (CFG.main_rdiv < RDIV_MIN) [*4] |-> RDIV_FAULT; endproperty
   a_rdiv: assert property (p_rdiv) else $error("illegal divide not flagged");

   cover property (PSEL && PENABLE && PSLVERR);
   cover property ($fell(MAIN_ACTIVE));
   cover property ($rose(RDIV_FAULT));
   cover property (ld_age == 5'h00);
endmodule

bind dssp_top dssp_monitor u_mon (
   .REF_CLK(REF_CLK), .RST_N(RST_N), .LOAD_STROBE(LOAD_STROBE), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .MULTIPLEXED_STATUS_PIN(MULTIPLEXED_STATUS_PIN), .MULTIPLEXED_STATUS_PIN_OE_N(MULTIPLEXED_STATUS_PIN_OE_N),
   .CFG(CFG), .MAIN_ACTIVE(MAIN_ACTIVE), .AUX_ACTIVE(AUX_ACTIVE), .RDIV_FAULT(RDIV_FAULT)
);
`default_nettype wire

// *** dssp_ctl_model.sv ***
// Serial controller model: shifts words and pulses the load strobe
`timescale 1ns/1ps
`default_nettype none
module dssp_ctl_model (
   output var logic serial_clock,
   output var logic serial_data,
   output var logic load_strobe
);
   localparam int HALF = 24;

   initial begin
      serial_clock = 1'b0;
      serial_data = 1'b0;
      load_strobe = 1'b0;
   end

   // Clock stands still between words; gap lets a caller answer slowly
   task automatic send(input logic [21:0] w, input logic ld, input int gap);
      for (int i = 21; i >= 0; i--) begin
         serial_data = w[i];
         #HALF serial_clock = 1'b1;
         #HALF serial_clock = 1'b0;
      end
      // Released data line never shows the last bit
      serial_data = ~serial_data;
      #(HALF + gap);
      load_strobe = ld;
      // Pulse outlasts one system clock period so every sampler sees it
      #(4 * HALF) load_strobe = 1'b0;
      #(4 * HALF);
   endtask
endmodule
`default_nettype wire

// *** dssp_top_test.sv ***
// Self-checking bench: APB and serial programming of the port
`timescale 1ns/1ps
`default_nettype none
module dssp_top_test
   import dssp_pkg::*;
;
   localparam logic [19:0] PAY [4] = '{20'h9_0003, 20'h4_0100, 20'h0_8005, 20'h4_0030};
   localparam logic [1:0]  SELS [4] = '{SEL_MAIN_R, SEL_MAIN_N, SEL_AUX_R, SEL_AUX_N};
   // Fields: mode, gp, ndiv, rdiv, main lock, aux lock, pin, oe_n
   localparam logic [9:0]  MUXT [9] = '{{MUX_GP_LOW, 5'h10, 2'h0}, {MUX_GP_HIGH, 5'h10, 2'h2},
      {MUX_NDIV, 5'h08, 2'h2}, {MUX_RDIV, 5'h04, 2'h2}, {MUX_LOCK_MAIN, 5'h02, 2'h1},
      {MUX_LOCK_AUX, 5'h01, 2'h1}, {MUX_HIZ, 5'h1f, 2'h1}, {MUX_LOCK_MAIN, 5'h01, 2'h0},
      {MUX_FASTACQ, 5'h00, 2'h1}};
   logic        ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
   logic        main_lock, aux_lock, ndiv_o, rdiv_o, sclk, sdata, strobe;
   logic        pin, pin_oe_n, main_active, aux_active, rdiv_fault;
   logic [7:0]  paddr;
   logic [9:0]  ent;
   logic [31:0] pwdata, prdata, rd;
   dssp_cfg_s   cfg;
   int          failures, check_count, cycles;

   dssp_ctl_model u_ctl (.serial_clock(sclk), .serial_data(sdata), .load_strobe(strobe));
   dssp_top dut (
      .REF_CLK(ref_clk), .RST_N(rst_n), .SERIAL_CLOCK(sclk), .SERIAL_DATA(sdata),
      .LOAD_STROBE(strobe), .MAIN_LOCK(main_lock), .AUX_LOCK(aux_lock), .MAIN_NDIV_OUT(ndiv_o),
      .MAIN_RDIV_OUT(rdiv_o), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .MULTIPLEXED_STATUS_PIN(pin), .MULTIPLEXED_STATUS_PIN_OE_N(pin_oe_n), .CFG(cfg),
      .MAIN_ACTIVE(main_active), .AUX_ACTIVE(aux_active), .RDIV_FAULT(rdiv_fault)
   );

   always #25 ref_clk = ~ref_clk;

   task automatic final_report;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         final_report();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) failures++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [19:0] p);
      apb(1'b0, a, ZERO32);
      chk("register", {12'h000, p}, rd);
   endtask

   task automatic ld(input logic [19:0] p, input logic [1:0] s, input logic on, input int gap);
      u_ctl.send({p, s}, on, gap);
      wt(12);
   endtask

   task automatic pwd(input logic [19:0] m, input logic [19:0] a, input logic [1:0] e);
      apb(1'b1, A_MAIN_R, {12'h000, m});
      apb(1'b1, A_AUX_R, {12'h000, a});
      wt(6);
      chk("active", {30'h0000_0000, e}, {30'h0000_0000, main_active, aux_active});
   endtask

   task automatic fault_chk(input logic [14:0] v, input logic e);
      apb(1'b1, A_MAIN_R, {17'h0_0000, v});
      wt(6);
      chk("fault", {31'h0000_0000, e}, {31'h0000_0000, rdiv_fault});
   endtask

   initial begin
      ref_clk = 1'b0;
      rst_n = 1'b0;
      {psel, penable, pwrite, main_lock, aux_lock, ndiv_o, rdiv_o} = 7'h00;
      paddr = 8'h00;
      pwdata = ZERO32;
      wt(16);
      rst_n <= 1'b1;
      chk("cfg_reset", ZERO32, {31'h0000_0000, |cfg});
      for (int i = 0; i < 4; i++) rchk(8'(4 * i), 20'h0_0000);
      rchk(A_CONTROL, 20'h0_0001);
      // Serial side has no reset: prime it once
      ld(20'h0_0000, SEL_AUX_R, 1'b1, 0);
      for (int i = 0; i < 4; i++) ld(PAY[i], SELS[i], 1'b1, 40 * i);
      for (int i = 0; i < 4; i++) rchk(8'(4 * i), PAY[i]);
      chk("cfg_bits", 32'h0000_001f, {25'h000_0000, cfg.main_cp_hiz, cfg.aux_cp_high, cfg.main_fast_acq,
         cfg.main_cp_high, cfg.main_prescale_32, cfg.aux_cp_hiz, cfg.aux_prescale_16});
      chk("rdiv", {1'b0, 15'h0003, 1'b0, 15'h0005}, {1'b0, cfg.main_rdiv, 1'b0, cfg.aux_rdiv});
      chk("ndiv", 32'h0000_0100, {14'h0000, cfg.main_ndiv});
      chk("aux_ndiv", 32'h0000_0030, {14'h0000, cfg.aux_ndiv});
      ld(20'h0_0007, SEL_MAIN_R, 1'b0, 0);
      rchk(A_MAIN_R, PAY[0]);
      ld(20'h0_0007, SEL_MAIN_R, 1'b1, 0);
      rchk(A_MAIN_R, 20'h0_0007);
      apb(1'b1, A_CONTROL, ZERO32);
      ld(20'h0_0009, SEL_MAIN_R, 1'b1, 0);
      rchk(A_MAIN_R, 20'h0_0007);
      apb(1'b1, 8'h1c, 32'h0000_0055);
      chk("slverr", 32'h0000_0001, {31'h0000_0000, er});
      apb(1'b0, 8'h1c, ZERO32);
      chk("unmapped", 32'h0000_0001, rd | {31'h0000_0000, er});
      for (int i = 0; i < 9; i++) begin
         ent = MUXT[i];
         apb(1'b1, A_CONTROL, {30'h0000_0000, ent[6], 1'b1});
         {ndiv_o, rdiv_o, main_lock, aux_lock} <= ent[5:2];
         apb(1'b1, A_MAIN_N, {14'h0000, ent[9:7], 15'h0100});
         wt(6);
         chk("pin", {30'h0000_0000, ent[1:0]}, {30'h0000_0000, pin & ~ent[0], pin_oe_n});
      end
      ndiv_o <= 1'b0;
      pwd(20'h6_0003, 20'h0_0005, 2'h1);
      pwd(20'h0_0003, 20'h6_0005, 2'h2);
      // Sync power-down waits for a feedback pulse
      pwd(20'h2_0003, 20'h0_0005, 2'h3);
      ndiv_o <= 1'b1;
      wt(8);
      chk("sync_off", 32'h0000_0001, {30'h0000_0000, main_active, aux_active});
      ndiv_o <= 1'b0;
      fault_chk(15'h0001, 1'b1);
      fault_chk(RDIV_MIN, 1'b0);
      fault_chk(RDIV_MAX, 1'b0);
      final_report();
   end
endmodule
`default_nettype wire
